// >>> rtc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  seconds counter block.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

`define MISC_CONFIG_OFS     12'h500
`define ELAPSED_SECONDS_OFS 12'h50C
`define IRQ_STATUS_OFS      12'h510
`define IRQ_MASK_OFS        12'h514

`define MISC_CLEAR_BIT      0
`define MISC_LOSS_BIT       1
`define MISC_SPARE_LSB      2

`define IRQ_TICK_BIT        0
`define IRQ_LOSS_BIT        1

`define MISC_CONFIG_RST     32'h0000_0000
`define IRQ_MASK_RST        2'h0
`define IRQ_STATUS_RST      2'h0

`define XTAL_HZ             32768
`define XTAL_EDGES_PER_SEC  15'h7FFF

`endif

// >>> rtc_pkg.sv
/*
  Types shared by the seconds counter block.
  Assumes rtc_map.svh is on the include path.
*/
package rtc_pkg;
  typedef logic [31:0] word_t;
  typedef logic [14:0] presc_t;
  typedef logic [1:0]  irq_t;
  typedef logic [11:0] ofs_t;
endpackage

// >>> tick_if.sv
/*
  Carrier between the crystal divider and the register block.
  Assumes one clock domain, clk_i.
*/
interface tick_if;
  logic sec_tick;
  logic xtal_level;
  modport src (output sec_tick, output xtal_level);
  modport dst (input  sec_tick, input  xtal_level);
endinterface

// >>> xtal_divider.sv
/*
  Samples the crystal pin and divides its edges down to a one-second pulse.
  Assumes clk_i is far faster than the crystal; backup_ok_i low clears it.
*/
`include "rtc_map.svh"
module xtal_divider (
  input  wire logic clk_i,
  input  wire logic crystal_in_i,
  input  wire logic backup_ok_i,
  tick_if.src       tick
);
  logic           sync1_r;
  logic           sync2_r;
  logic           last_r;
  rtc_pkg::presc_t presc_r;
  logic           edge_w;

  // Two-stage sampler; first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    sync1_r <= crystal_in_i;
    sync2_r <= sync1_r;
    last_r  <= sync2_r;
  end

  assign edge_w = sync2_r & ~last_r;

  // No system reset here: the divider lives on the battery
  always_ff @(posedge clk_i)
  begin
    if (!backup_ok_i)
      presc_r <= '0;
    else if (edge_w)
      presc_r <= presc_r + 15'h0001;
  end

  assign tick.sec_tick   = edge_w & backup_ok_i & (presc_r == `XTAL_EDGES_PER_SEC);
  assign tick.xtal_level = sync2_r;
endmodule // xtal_divider

// >>> apb_decode.sv
/*
  APB address decoder for the seconds counter block.
  Assumes word-aligned 32-bit accesses; paddr low 12 bits decoded.
*/
`include "rtc_map.svh"
module apb_decode (
  input  wire logic [11:0] paddr_i,
  output wire logic        sel_misc_o,
  output wire logic        sel_time_o,
  output wire logic        sel_stat_o,
  output wire logic        sel_mask_o,
  output wire logic        mapped_o
);
  function automatic logic hit(input rtc_pkg::ofs_t a, input rtc_pkg::ofs_t o);
    hit = (a == o);
  endfunction

  assign sel_misc_o = hit(paddr_i, `MISC_CONFIG_OFS);
  assign sel_time_o = hit(paddr_i, `ELAPSED_SECONDS_OFS);
  assign sel_stat_o = hit(paddr_i, `IRQ_STATUS_OFS);
  assign sel_mask_o = hit(paddr_i, `IRQ_MASK_OFS);
  assign mapped_o   = sel_misc_o | sel_time_o | sel_stat_o | sel_mask_o;
endmodule // apb_decode

// >>> battery_backed_seconds_counter.sv
/*
  Battery-backed elapsed-seconds counter with APB register access, a sticky
  power-loss flag and a maskable interrupt.
  Assumes one 40 MHz clock, crystal pin sampled synchronously, and an
  external comparator reporting the backup supply as backup_ok_i.
*/
//
// Overview of operation
// - Timebase from 32.768 kHz crystal pins
// - Free-running 32-bit seconds counter
// - Count up once per crystal second
// - Counter read-only at 0x50C, writes ignored
// - No system reset touches the counter
// - Counts seconds since backup supply applied
// - Keeps counting while supply stays good
// - Low backup supply sets power-loss flag
// - Flag holds until clear bit written
// - Config register 0x500 holds clear, status
`include "rtc_map.svh"
module battery_backed_seconds_counter (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        crystal_in_i,
  output wire logic        crystal_out_o,
  input  wire logic        backup_ok_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output wire logic [31:0] prdata_o,
  output wire logic        pready_o,
  output wire logic        pslverr_o,
  output wire logic        irq_o
);
  tick_if tick ();

  rtc_pkg::word_t seconds_r;
  rtc_pkg::word_t misc_r;
  rtc_pkg::word_t prdata_r;
  rtc_pkg::irq_t  status_r;
  rtc_pkg::irq_t  status_nxt;
  rtc_pkg::irq_t  mask_r;
  logic           loss_r;
  logic           loss_nxt;
  logic           err_r;
  logic           sel_misc;
  logic           sel_time;
  logic           sel_stat;
  logic           sel_mask;
  logic           mapped;
  logic           setup_w;
  logic           wr_w;
  logic           clear_w;

  xtal_divider u_div (
    .clk_i        (clk_i),
    .crystal_in_i (crystal_in_i),
    .backup_ok_i  (backup_ok_i),
    .tick         (tick.src)
  );

  apb_decode u_dec (
    .paddr_i    (paddr_i[11:0]),
    .sel_misc_o (sel_misc),
    .sel_time_o (sel_time),
    .sel_stat_o (sel_stat),
    .sel_mask_o (sel_mask),
    .mapped_o   (mapped)
  );

  // Oscillator inverter back to the crystal
  assign crystal_out_o = ~tick.xtal_level;

  // Battery domain: rst_i deliberately absent, counter only restarts on supply-up
  always_ff @(posedge clk_i)
  begin
    if (!backup_ok_i)
      seconds_r <= '0;
    else if (tick.sec_tick)
      seconds_r <= seconds_r + 32'h0000_0001;
  end

  assign setup_w = psel_i & ~penable_i;
  assign wr_w    = psel_i & penable_i & pwrite_i;
  assign clear_w = wr_w & sel_misc & pwdata_i[`MISC_CLEAR_BIT];

  // Set beats clear so a supply dip during the clear write is not lost
  always_comb
  begin
    loss_nxt = loss_r;
    if (clear_w)
      loss_nxt = 1'b0;
    if (!backup_ok_i)
      loss_nxt = 1'b1;
  end

  // Flag survives system reset: it reports battery history, not boot state
  always_ff @(posedge clk_i)
  begin
    loss_r <= loss_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      misc_r <= `MISC_CONFIG_RST;
    else if (wr_w && sel_misc)
      misc_r <= {pwdata_i[31:`MISC_SPARE_LSB], 2'h0};
  end

  always_comb
  begin
    status_nxt = status_r;
    if (wr_w && sel_stat)
      status_nxt = status_r & ~pwdata_i[1:0];
    if (tick.sec_tick)
      status_nxt[`IRQ_TICK_BIT] = 1'b1;
    if (!backup_ok_i)
      status_nxt[`IRQ_LOSS_BIT] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_r <= `IRQ_STATUS_RST;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_r <= `IRQ_MASK_RST;
    else if (wr_w && sel_mask)
      mask_r <= pwdata_i[1:0];
  end

  // Snapshot at setup: one whole word, taken between increments
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prdata_r <= '0;
      err_r    <= 1'b0;
    end
    else if (setup_w)
    begin
      err_r <= ~mapped;
      if (sel_time)
        prdata_r <= seconds_r;
      else if (sel_misc)
        prdata_r <= {misc_r[31:`MISC_SPARE_LSB], loss_r, 1'b0};
      else if (sel_stat)
        prdata_r <= {30'h0, status_r};
      else if (sel_mask)
        prdata_r <= {30'h0, mask_r};
      else
        prdata_r <= '0;
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & err_r;
  assign irq_o     = |(status_r & mask_r);
endmodule // battery_backed_seconds_counter

// >>> rtc_chk.sv
/* Port checker for the seconds counter block.
   Assumes binding onto the top module and one clock domain. */
module rtc_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        crystal_in_i,
  input wire logic        crystal_out_o,
  input wire logic        backup_ok_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [11:0] a   = paddr_i[11:0];
  wire        acc = psel_i && penable_i;
  wire        map = a == 12'h500 || a == 12'h50C || a == 12'h510 || a == 12'h514;
  wire        mwr = acc && pwrite_i && a == 12'h514;
  sequence s_low;
    !backup_ok_i [*3];
  endsequence
  sequence s_rd(ofs);
    psel_i && !penable_i && !pwrite_i && a == ofs;
  endsequence
  property p_ready; acc |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err; acc && !map |-> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  // Two sampler stages: the drive is the pin level of two edges ago, always
  property p_xout; crystal_out_o == !$past(crystal_in_i, 2); endproperty
  a_xout: assert property (p_xout) else $error("crystal drive not inverse");
  property p_zero; s_low ##0 s_rd(12'h50C) |=> prdata_o == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("count not zero without supply");
  property p_loss; s_low ##0 s_rd(12'h500) |=> prdata_o[1]; endproperty
  a_loss: assert property (p_loss) else $error("loss flag not set");
  property p_clr0; acc && !pwrite_i && a == 12'h500 |-> !prdata_o[0]; endproperty
  a_clr0: assert property (p_clr0) else $error("clear bit reads one");
  property p_irq_on; !backup_ok_i [*2] ##0 (mwr && pwdata_i[1]) |=> irq_o; endproperty
  a_irq_on: assert property (p_irq_on) else $error("loss interrupt missing");
  property p_irq_off; mwr && pwdata_i[1:0] == 2'h0 |=> !irq_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt high");
endmodule // rtc_chk
bind battery_backed_seconds_counter rtc_chk u_chk (.*);

// >>> xtal_model.sv
/* Crystal and backup battery model.
   Assumes clk_i far faster than the crystal it stands for. */
// One clock per crystal level: the sampler follows it, and a second stays near 65536 cycles
module xtal_model #(parameter int HALF = 1) (
  input  wire logic clk_i,
  input  wire logic bat_on_i,
  output logic      backup_ok_o,
  output logic      crystal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  initial crystal_o = 1'h0;
  assign backup_ok_o = bat_on_i;
  // Oscillator is battery powered, so it stalls without it
  always @(posedge clk_i)
  begin
    n <= bat_on_i ? (n + 1) % HALF : 0;
    if (bat_on_i && n == HALF - 1)
      crystal_o <= !crystal_o;
  end
endmodule // xtal_model

// >>> battery_backed_seconds_counter_bench.sv
/* Self-checking bench for the seconds counter block.
   Assumes the crystal model and the bound port checker. */
module battery_backed_seconds_counter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, bat = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata_o, r;
  logic        pready_o, pslverr_o, irq_o, xtal, ok;
  logic [32:0] exp_q[$];
  int          err_total = 0, comparisons = 0, cyc = 0;
  always #12.5 clk_i = !clk_i;
  xtal_model u_xtal (.clk_i(clk_i), .bat_on_i(bat), .backup_ok_o(ok), .crystal_o(xtal));
  battery_backed_seconds_counter u_dut (.clk_i(clk_i), .rst_i(rst_i), .crystal_in_i(xtal),
    .crystal_out_o(), .backup_ok_i(ok), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o));
  task automatic check(input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    $display("%0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Read expectations carry the error flag above the data word
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_i);
    penable <= 1'h1;
    do @(posedge clk_i); while (pready_o !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic irq_is(input logic v);
    @(posedge clk_i);
    check({32'h0, irq_o}, {32'h0, v});
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (psel && penable && pready_o === 1'h1 && !pwrite)
      check({pslverr_o, prdata_o}, exp_q.pop_front());
    // Whole run is near 65700 cycles
    if (cyc == 80000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    void'($urandom(16));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    apb(1'h0, 12'h500, 32'h0, 33'h2);
    apb(1'h0, 12'h50C, 32'h0, 33'h0);
    bat <= 1'h1;
    apb(1'h0, 12'h500, 32'h0, 33'h2);
    apb(1'h1, 12'h500, 32'h1, 33'h0);
    apb(1'h0, 12'h500, 32'h0, 33'h0);
    r = $urandom & 32'hFFFF_FFFC;
    apb(1'h1, 12'h500, r, 33'h0);
    apb(1'h0, 12'h500, 32'h0, {1'h0, r});
    apb(1'h1, 12'h50C, $urandom, 33'h0);
    apb(1'h0, 12'h50C, 32'h0, 33'h0);
    apb(1'h0, 12'h504, 32'h0, 33'h1_0000_0000);
    apb(1'h1, 12'h510, 32'h3, 33'h0);
    $display("register test done");
    // Crystal rises every second clock: first tick lands near 65540 cycles after supply-up
    repeat (32768 * 2 + 40) @(posedge clk_i);
    apb(1'h0, 12'h50C, 32'h0, 33'h1);
    apb(1'h0, 12'h510, 32'h0, 33'h1);
    apb(1'h1, 12'h514, 32'h1, 33'h0);
    irq_is(1'h1);
    apb(1'h1, 12'h510, 32'h1, 33'h0);
    irq_is(1'h0);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    apb(1'h0, 12'h50C, 32'h0, 33'h1);
    $display("seconds test done");
    bat <= 1'h0;
    apb(1'h1, 12'h514, 32'h2, 33'h0);
    irq_is(1'h1);
    apb(1'h0, 12'h50C, 32'h0, 33'h0);
    apb(1'h0, 12'h500, 32'h0, 33'h2);
    apb(1'h1, 12'h514, 32'h0, 33'h0);
    irq_is(1'h0);
    $display("battery test done");
    conclude();
  end
endmodule // battery_backed_seconds_counter_bench
